// ---- ssw_host.sv ----
// Host SPI controller model that frames commands on the serial link
module ssw_host (
   // Serial link
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Clock rests low outside frames; data is flipped on release so no stale bit lingers
   task automatic xfer(input int nb, input logic [39:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      #3 cs_n = 1'b0;
      for (int i = 0; i < nb; i++) begin
         mosi = tx[39-i];
         #40 sclk = 1'b1;
         rx = {rx[6:0], miso};
         #40 sclk = 1'b0;
      end
      #20 cs_n = 1'b1;
      mosi = ~mosi;
      // Gap well above the minimum deselect time
      #200;
   endtask : xfer
endmodule : ssw_host

// ---- ssw_link.sv ----
// Serial-clock side: frame shifter and status read-out
module ssw_link (
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // Core side
   input wire logic rst_n,
   input wire logic [7:0] stat_i,
   output ssw_pkg::ssw_frame_t frame_o
);
   import ssw_pkg::*;

   typedef struct packed {
      logic [7:0] sh;
      ssw_frame_t fr;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] sv;
      logic [7:0] snap;
   } ssw_lk_t;

   ssw_lk_t q;
   ssw_lk_t d;
   logic fresh_q;
   logic miso_q;
   logic rd;

   // Set while deselected so the first edge of a frame restarts the count
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   always_comb begin
      ssw_frame_t f;
      logic [7:0] sh;
      f = fresh_q ? '0 : q.fr;
      sh = fresh_q ? 8'h00 : q.sh;
      d = q;
      d.s1 = stat_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < 8; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.sv[i] = q.s3[i];
         end
      end
      d.sh = {sh[6:0], mosi};
      d.fr = f;
      d.fr.lo3 = f.lo3 + 3'd1;
      if (f.lo3 == 3'd7) begin
         unique case (f.nb)
            4'h0: d.fr.op = d.sh;
            4'h1: d.fr.b1 = d.sh;
            4'h2: d.fr.b2 = d.sh;
            4'h3: d.fr.b3 = d.sh;
            default: ;
         endcase
         if (f.nb != NB_MAX) begin
            d.fr.nb = f.nb + 4'h1;
         end
         // One snapshot per byte keeps a read byte self-consistent
         d.snap = q.sv;
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rd = !fresh_q && q.fr.op == OP_RSR && q.fr.nb != 4'h0;

   // Output changes on the falling edge, MSB first, repeating
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= rd ? q.snap[3'd7 - q.fr.lo3] : 1'b0;
      end
   end

   assign miso = miso_q;
   assign miso_oe = !cs_n && rd;
   assign frame_o = q.fr;
endmodule : ssw_link

// ---- ssw_pkg.sv ----
// Shared constants and types for the status write-protect block
package ssw_pkg;
   // Clock and self-timed cycle times
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned TSTAT_NS = 5000000;
   localparam int unsigned TPROG_NS = 1000000;
   localparam int unsigned TSECT_NS = 50000000;
   localparam int unsigned TCHIP_NS = 200000000;
   localparam int unsigned TSTAT_CYC = (TSTAT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TPROG_CYC = (TPROG_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TSECT_CYC = (TSECT_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TCHIP_CYC = (TCHIP_NS + CLK_NS - 1) / CLK_NS;
   // Opcodes
   localparam logic [7:0] OP_WSR = 8'h01;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_WDI = 8'h04;
   localparam logic [7:0] OP_RSR = 8'h05;
   localparam logic [7:0] OP_WEN = 8'h06;
   localparam logic [7:0] OP_SECT = 8'hD8;
   localparam logic [7:0] OP_CHIP = 8'hC7;
   // Frame lengths in whole bytes
   localparam logic [3:0] NB_CMD = 4'h1;
   localparam logic [3:0] NB_WSR = 4'h2;
   localparam logic [3:0] NB_SECT = 4'h4;
   localparam logic [3:0] NB_PROG = 4'h5;
   localparam logic [3:0] NB_MAX = 4'hF;
   // Status byte layout
   localparam int unsigned SR_BUSY = 0;
   localparam int unsigned SR_WLATCH = 1;
   localparam int unsigned SR_BP_LO = 2;
   localparam int unsigned SR_BP_HI = 4;
   localparam int unsigned SR_LOCK = 7;
   // Protected area granule and address width
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned PROT_LOG2 = 16;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [2:0] lo3;
      logic [3:0] nb;
   } ssw_frame_t;
   typedef struct packed {
      logic wr_lock;
      logic [2:0] bp;
   } ssw_nv_t;
   typedef enum logic [1:0] {ARR_PROG = 2'b00, ARR_SECT = 2'b01, ARR_CHIP = 2'b10} ssw_kind_t;
   typedef struct packed {
      logic valid;
      ssw_kind_t kind;
      logic [ADDR_W-1:0] addr;
   } ssw_arr_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WSR = 2'b01, ST_PROG = 2'b10, ST_ERASE = 2'b11} ssw_state_t;
   localparam logic [1:0] SYNC_RST = 2'h3;
endpackage : ssw_pkg

// ---- ssw_top.sv ----
// Status register and write-protection logic of a serial flash
module ssw_top #(
   parameter int unsigned TSTAT_CYC = ssw_pkg::TSTAT_CYC,
   parameter int unsigned TPROG_CYC = ssw_pkg::TPROG_CYC,
   parameter int unsigned TSECT_CYC = ssw_pkg::TSECT_CYC,
   parameter int unsigned TCHIP_CYC = ssw_pkg::TCHIP_CYC
) (
   // System
   input wire logic clk,
   input wire logic rst_n,
   // Serial link and write-protect pin
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic wp_n,
   // Non-volatile store
   input ssw_pkg::ssw_nv_t nv_init,
   output logic nv_wr,
   output ssw_pkg::ssw_nv_t nv_wr_data,
   // Array engine and state
   output ssw_pkg::ssw_arr_t arr_req,
   output logic [7:0] status_o,
   output logic hw_protect
);
   import ssw_pkg::*;

   typedef struct packed {
      logic [1:0] p1;
      logic [1:0] p2;
      logic [1:0] p3;
      logic cs_n;
      logic wp_n;
      logic loaded;
      ssw_state_t state;
      logic [31:0] tmr;
      logic we_latch;
      ssw_nv_t nv;
      ssw_nv_t pend;
      ssw_arr_t arr;
      logic nv_wr;
   } ssw_core_t;

   localparam ssw_core_t CORE_RST = '{
      p1: SYNC_RST, p2: SYNC_RST, p3: SYNC_RST, cs_n: 1'b1, wp_n: 1'b1,
      loaded: 1'b0, state: ST_IDLE, tmr: '0, we_latch: 1'b0, nv: '0, pend: '0,
      arr: '0, nv_wr: 1'b0};

   ssw_core_t q;
   ssw_core_t d;
   logic [1:0] rsync_q;
   logic rst_s_n;
   ssw_frame_t fr;
   logic end_ev;
   logic busy;
   logic hw_lock;
   logic whole;
   logic [ADDR_W-1:0] addr;

   // Area guarded by the protect field: the top 2^(bp-1) granules, all at 7
   function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [2:0] bp);
      logic [ADDR_W:0] top;
      logic [ADDR_W:0] lim;
      top = (ADDR_W+1)'(1) << ADDR_W;
      lim = top - (((ADDR_W+1)'(1) << PROT_LOG2) << (bp - 3'd1));
      if (bp == 3'd0) begin
         return 1'b0;
      end
      if (bp == 3'd7) begin
         return 1'b1;
      end
      return {1'b0, a} >= lim;
   endfunction : prot_hit

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsync_q <= 2'b00;
      end else begin
         rsync_q <= {rsync_q[0], 1'b1};
      end
   end
   assign rst_s_n = rsync_q[1];

   ssw_link u_link (
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .rst_n(rst_s_n),
      .stat_i(status_o),
      .frame_o(fr)
   );

   // Frame fields are read only after select has risen, when the serial clock is idle
   assign end_ev = q.loaded && !q.cs_n && q.p2[1] == q.p3[1] && q.p3[1];
   assign busy = q.state != ST_IDLE;
   assign hw_lock = q.nv.wr_lock && !q.wp_n;
   assign whole = fr.lo3 == 3'd0;
   assign addr = {fr.b1, fr.b2, fr.b3};

   always_comb begin
      d = q;
      d.p1 = {cs_n, wp_n};
      d.p2 = q.p1;
      d.p3 = q.p2;
      if (q.p2[1] == q.p3[1]) begin
         d.cs_n = q.p3[1];
      end
      if (q.p2[0] == q.p3[0]) begin
         d.wp_n = q.p3[0];
      end
      d.nv_wr = 1'b0;
      d.arr.valid = 1'b0;
      // Retained field comes back from the store once after reset
      if (!q.loaded) begin
         d.loaded = 1'b1;
         d.nv = nv_init;
      end
      // Busy device ignores every write-type frame
      if (end_ev && !busy && whole) begin
         unique case (fr.op)
            OP_WEN: begin
               if (fr.nb == NB_CMD) begin
                  d.we_latch = 1'b1;
               end
            end
            OP_WDI: begin
               if (fr.nb == NB_CMD) begin
                  d.we_latch = 1'b0;
               end
            end
            OP_WSR: begin
               if (fr.nb == NB_WSR && q.we_latch && !hw_lock) begin
                  d.state = ST_WSR;
                  d.tmr = TSTAT_CYC - 1;
                  d.pend = {fr.b1[SR_LOCK], fr.b1[SR_BP_HI:SR_BP_LO]};
               end
            end
            OP_PROG: begin
               if (fr.nb >= NB_PROG && q.we_latch && !prot_hit(addr, q.nv.bp)) begin
                  d.state = ST_PROG;
                  d.tmr = TPROG_CYC - 1;
                  d.arr = '{valid: 1'b1, kind: ARR_PROG, addr: addr};
               end
            end
            OP_SECT: begin
               if (fr.nb == NB_SECT && q.we_latch && !prot_hit(addr, q.nv.bp)) begin
                  d.state = ST_ERASE;
                  d.tmr = TSECT_CYC - 1;
                  d.arr = '{valid: 1'b1, kind: ARR_SECT, addr: addr};
               end
            end
            OP_CHIP: begin
               if (fr.nb == NB_CMD && q.we_latch && q.nv.bp == 3'd0) begin
                  d.state = ST_ERASE;
                  d.tmr = TCHIP_CYC - 1;
                  d.arr = '{valid: 1'b1, kind: ARR_CHIP, addr: '0};
               end
            end
            default: ;
         endcase
      end
      // Self-timed cycle: latch drops at the end of every kind
      if (busy) begin
         if (q.tmr == 32'h0) begin
            d.state = ST_IDLE;
            d.we_latch = 1'b0;
            if (q.state == ST_WSR) begin
               d.nv = q.pend;
               d.nv_wr = 1'b1;
            end
         end else begin
            d.tmr = q.tmr - 32'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         q <= CORE_RST;
      end else begin
         q <= d;
      end
   end

   assign status_o = {q.nv.wr_lock, 2'b00, q.nv.bp, q.we_latch, busy};
   assign nv_wr = q.nv_wr;
   assign nv_wr_data = q.nv;
   assign arr_req = q.arr;
   assign hw_protect = hw_lock;

   // Length of the running status write cycle, for checking only
   logic [31:0] wlen_q;
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         wlen_q <= 32'h0;
      end else begin
         wlen_q <= (q.state == ST_WSR) ? wlen_q + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_s_n);

   property p_no_latch;
      (end_ev && !q.we_latch && !busy) |=> !busy;
   endproperty
   a_no_latch: assert property (p_no_latch) else $error("write accepted without latch");

   property p_nv_only_wsr;
      ($past(q.loaded) && $changed(q.nv)) |-> $past(q.state) == ST_WSR;
   endproperty
   a_nv_only_wsr: assert property (p_nv_only_wsr) else $error("protect field changed outside write");

   property p_prot;
      (q.arr.valid && q.arr.kind != ARR_CHIP) |-> !prot_hit(q.arr.addr, q.nv.bp);
   endproperty
   a_prot: assert property (p_prot) else $error("protected area accepted");

   property p_chip_bp0;
      (q.arr.valid && q.arr.kind == ARR_CHIP) |-> q.nv.bp == 3'd0 && busy;
   endproperty
   a_chip_bp0: assert property (p_chip_bp0) else $error("chip erase with protect set");

   property p_lock_block;
      (end_ev && hw_lock && !busy) |=> q.state != ST_WSR;
   endproperty
   a_lock_block: assert property (p_lock_block) else $error("status write in hw protect");

   property p_wsr_start;
      (end_ev && !busy && whole && fr.op == OP_WSR && fr.nb == NB_WSR && q.we_latch && !hw_lock) |=> q.state == ST_WSR;
   endproperty
   a_wsr_start: assert property (p_wsr_start) else $error("allowed status write refused");

   property p_lock_frozen;
      (q.loaded && hw_lock && !busy) |=> $stable(q.nv);
   endproperty
   a_lock_frozen: assert property (p_lock_frozen) else $error("protect field changed in hw protect");

   property p_nv_wr_src;
      q.nv_wr |-> $past(q.state) == ST_WSR;
   endproperty
   a_nv_wr_src: assert property (p_nv_wr_src) else $error("store written outside status write");

   property p_arr_pulse;
      q.arr.valid |=> !q.arr.valid;
   endproperty
   a_arr_pulse: assert property (p_arr_pulse) else $error("array request longer than one cycle");

   property p_arr_busy;
      q.arr.valid |-> busy;
   endproperty
   a_arr_busy: assert property (p_arr_busy) else $error("array cycle without busy");

   property p_latch_hold;
      (q.loaded && !busy && !end_ev) |=> $stable(q.we_latch);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch moved without command");

   property p_lock_exit;
      $rose(q.wp_n) |-> !hw_lock;
   endproperty
   a_lock_exit: assert property (p_lock_exit) else $error("hw protect kept after pin high");

   property p_wsr_frame;
      (end_ev && fr.op == OP_WSR && (fr.nb != NB_WSR || !whole)) |=> q.state != ST_WSR;
   endproperty
   a_wsr_frame: assert property (p_wsr_frame) else $error("bad status write frame accepted");

   property p_b65;
      status_o[6:5] == 2'b00 && status_o[SR_BUSY] == (q.state != ST_IDLE);
   endproperty
   a_b65: assert property (p_b65) else $error("status byte layout wrong");

   property p_wsr_len;
      $fell(q.state == ST_WSR) |-> wlen_q == TSTAT_CYC && q.nv_wr;
   endproperty
   a_wsr_len: assert property (p_wsr_len) else $error("status write cycle length wrong");

   property p_latch_end;
      (busy && q.tmr == 32'h0) |=> !q.we_latch && !busy;
   endproperty
   a_latch_end: assert property (p_latch_end) else $error("latch not cleared at end");

   property p_write_enable_cmd;
      (end_ev && !busy && whole && fr.op == OP_WEN && fr.nb == NB_CMD) |=> q.we_latch ##1 q.we_latch;
   endproperty
   a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("write enable ignored");

   property p_write_disable_cmd;
      (end_ev && !busy && whole && fr.op == OP_WDI && fr.nb == NB_CMD) |=> !q.we_latch;
   endproperty
   a_write_disable_cmd: assert property (p_write_disable_cmd) else $error("write disable ignored");

   c_wsr_done: cover property ($fell(q.state == ST_WSR));
   c_lock_reject: cover property (end_ev && hw_lock && q.we_latch && fr.op == OP_WSR);
   c_prog: cover property (q.arr.valid && q.arr.kind == ARR_PROG);
   c_chip: cover property (q.arr.valid && q.arr.kind == ARR_CHIP);
   c_lock_enter: cover property ($rose(hw_lock));
endmodule : ssw_top

// ---- tb_top.sv ----
// Self-checking testbench for the status write-protect block
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ssw_pkg::*;
   // Self-timed cycles shortened so a status read still lands inside them
   localparam int unsigned TSTAT = 400;
   localparam int unsigned TA = 300;
   logic clk, rst_n, wp_n, sclk, cs_n, mosi, miso, miso_oe, nv_wr, hw_protect;
   ssw_nv_t nv_init, nv_wr_data;
   ssw_arr_t arr_req;
   logic [7:0] status_o, rx;
   logic [31:0] seed = 32'h196A90D2;
   int mismatches = 0, total_checks = 0, n_arr = 0, n_nv = 0, n_wsr = 0;
   int wr_lock, bp, we_latch, wp;
   ssw_kind_t last_kind;
   logic [23:0] last_addr;
   ssw_nv_t last_nv;

   ssw_top #(.TSTAT_CYC(TSTAT), .TPROG_CYC(TA), .TSECT_CYC(TA), .TCHIP_CYC(TA)) u_ssw_top (
      .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .wp_n(wp_n), .nv_init(nv_init), .nv_wr(nv_wr), .nv_wr_data(nv_wr_data),
      .arr_req(arr_req), .status_o(status_o), .hw_protect(hw_protect));
   ssw_host u_ssw_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (arr_req.valid === 1'b1) begin
         n_arr++;
         last_kind = arr_req.kind;
         last_addr = arr_req.addr;
      end
      if (nv_wr === 1'b1) begin
         n_nv++;
         last_nv = nv_wr_data;
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   function automatic logic [7:0] exp_sr(input int busy);
      return {wr_lock[0], 2'b00, bp[2:0], we_latch[0], busy[0]};
   endfunction : exp_sr

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   task automatic rd_chk(input int busy, input logic [7:0] m);
      u_ssw_host.xfer(16, {OP_RSR, 32'h0}, rx);
      chk(rx & m, exp_sr(busy) & m);
   endtask : rd_chk

   task automatic wait_idle();
      int n;
      n = 0;
      while (status_o[0] !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n == 2000) mismatches++;
      #1;
   endtask : wait_idle

   task automatic cmd(input logic [7:0] op, input int nb, input logic [31:0] arg);
      int na, ok;
      logic [7:0] m;
      na = n_arr;
      case (op)
         OP_WSR: ok = nb == 16 && we_latch == 1 && !(wr_lock == 1 && wp == 0);
         OP_CHIP: ok = nb == 8 && we_latch == 1 && bp == 0;
         OP_SECT: ok = nb == 32 && we_latch == 1 && bp == 0;
         OP_PROG: ok = nb == 40 && we_latch == 1 && bp == 0;
         default: ok = 0;
      endcase
      // Latch timing during array cycles is loose, so it is masked there
      m = (op == OP_WSR) ? 8'hFF : 8'hFD;
      u_ssw_host.xfer(nb, {op, arg}, rx);
      repeat (10) @(posedge clk);
      #1;
      if (op == OP_WEN) we_latch = 1;
      if (op == OP_WDI) we_latch = 0;
      if (ok) begin
         chk(status_o & m, exp_sr(1) & m);
         rd_chk(1, m);
         wait_idle();
         we_latch = 0;
         if (op == OP_WSR) begin
            wr_lock = arg[31];
            bp = arg[28:26];
            n_wsr++;
            chk({4'h0, last_nv}, {4'h0, wr_lock[0], bp[2:0]});
         end
      end
      chk(status_o, exp_sr(0));
      rd_chk(0, 8'hFF);
      chk(8'(n_arr - na), (ok && op != OP_WSR) ? 8'h01 : 8'h00);
      if (ok && op != OP_WSR) begin
         chk(8'(last_kind), (op == OP_CHIP) ? 8'(ARR_CHIP) : (op == OP_PROG) ? 8'(ARR_PROG) : 8'(ARR_SECT));
         chk(last_addr[23:16], (op == OP_CHIP) ? 8'h00 : arg[31:24]);
      end
   endtask : cmd

   task automatic set_wp(input int v);
      @(posedge clk);
      #1 wp_n = v[0];
      wp = v;
      repeat (6) @(posedge clk);
      #1 chk({7'h00, hw_protect}, (wr_lock == 1 && wp == 0) ? 8'h01 : 8'h00);
   endtask : set_wp

   initial begin
      #700us;
      mismatches++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      wp_n = 1'b1;
      wp = 1;
      nv_init = ssw_nv_t'(4'(xs()));
      wr_lock = nv_init.wr_lock;
      bp = nv_init.bp;
      we_latch = 0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (10) @(posedge clk);
      #1 chk(status_o, exp_sr(0));
      rd_chk(0, 8'hFF);
      $display("test reset_state done");
      cmd(OP_WSR, 16, 32'hFF00_0000);
      cmd(OP_WEN, 8, 0);
      cmd(OP_WDI, 8, 0);
      $display("test latch done");
      for (int i = 0; i < 4; i++) begin
         cmd(OP_WEN, 8, 0);
         cmd(OP_WSR, 16, xs());
      end
      cmd(OP_WEN, 8, 0);
      cmd(OP_WSR, 15, 32'hFF00_0000);
      cmd(OP_WSR, 17, 32'hFF00_0000);
      cmd(OP_WDI, 8, 0);
      $display("test status_write done");
      cmd(OP_WEN, 8, 0);
      cmd(OP_WSR, 16, 32'h9C00_0000);
      set_wp(0);
      cmd(OP_WEN, 8, 0);
      cmd(OP_WSR, 16, 32'h0000_0000);
      set_wp(1);
      cmd(OP_WEN, 8, 0);
      cmd(OP_WSR, 16, 32'h1C00_0000);
      set_wp(0);
      cmd(OP_WEN, 8, 0);
      cmd(OP_WSR, 16, 32'h9C00_0000);
      set_wp(0);
      set_wp(1);
      $display("test hw_protect done");
      cmd(OP_WEN, 8, 0);
      cmd(OP_CHIP, 8, 0);
      cmd(OP_SECT, 32, 32'h0001_0000);
      cmd(OP_PROG, 40, 32'h0002_0055);
      cmd(OP_WSR, 16, 32'h0000_0000);
      cmd(OP_WEN, 8, 0);
      cmd(OP_SECT, 32, 32'h0100_0000);
      cmd(OP_WEN, 8, 0);
      cmd(OP_PROG, 40, 32'h0203_0455);
      cmd(OP_WEN, 8, 0);
      cmd(OP_CHIP, 8, 0);
      cmd(OP_CHIP, 8, 0);
      chk(8'(n_nv), 8'(n_wsr));
      $display("test array_guard done");
      test_done();
   end
endmodule : tb_top
